// *** pkg/sec_erase_pkg.sv ***
// constants and types for the lock-erase and freeze command interpreter
package sec_erase_pkg;
    // command opcodes
    localparam logic [7:0] OP_SET_PASSWORD = 8'hF1;
    localparam logic [7:0] OP_ERASE_PREPARE = 8'hF3;
    localparam logic [7:0] OP_ERASE_UNIT = 8'hF4;
    localparam logic [7:0] OP_FREEZE = 8'hF5;
    localparam logic [7:0] OP_DISABLE_PASSWORD = 8'hF6;
    localparam logic [7:0] OP_UNLOCK = 8'hF2;

    // register offsets on the plain register port
    localparam logic [3:0] REG_COMMAND = 4'h0;
    localparam logic [3:0] REG_DATA = 4'h1;
    localparam logic [3:0] REG_ERROR_FLAGS = 4'h2;
    localparam logic [3:0] REG_COMPLETION_STATUS = 4'h3;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h4;
    localparam logic [3:0] REG_IRQ_MASK = 4'h5;
    localparam logic [3:0] REG_NATIVE_MAX = 4'h6;
    localparam logic [3:0] REG_LOCK_STATE = 4'h7;
    localparam logic [3:0] REG_ERASE_TIME = 4'h8;
    localparam logic [3:0] REG_ENH_ERASE_TIME = 4'h9;
    localparam logic [3:0] REG_USER_PW = 4'hA;
    localparam logic [3:0] REG_MASTER_PW = 4'hB;

    // field positions
    localparam int ERR_ABORT_BIT = 2;
    localparam int ST_ERR_BIT = 0;
    localparam int ST_DRQ_BIT = 3;
    localparam int ST_DSC_BIT = 4;
    localparam int ST_RDY_BIT = 6;
    localparam int ST_BSY_BIT = 7;
    localparam int CW_IDENT_BIT = 0;
    localparam int CW_MODE_BIT = 1;

    // sector layout in 16-bit words
    localparam logic [7:0] SECTOR_LAST_WORD = 8'hFF;
    localparam logic [7:0] PW_FIRST_WORD = 8'h01;
    localparam logic [7:0] PW_LAST_WORD = 8'h10;
    localparam int PW_WORDS = 16;

    // reset values
    localparam logic [31:0] NATIVE_MAX_RESET = 32'h0000_00FF;
    localparam logic [15:0] ERASE_TIME_RESET = 16'h0001;
    localparam logic [15:0] ENH_ERASE_TIME_RESET = 16'h0001;
    localparam logic [7:0] STATUS_IDLE = 8'h50;

    // interrupt status bits
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ABORT_BIT = 1;
    localparam int IRQ_DRQ_BIT = 2;
    localparam int IRQ_WIDTH = 3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RECV = 3'b001,
        ST_CHECK = 3'b011,
        ST_ERASE = 3'b010,
        ST_DONE = 3'b110
    } cmd_state_t;

    typedef struct packed {
        logic [31:0] lba;
        logic wr;
    } media_req_t;

    typedef struct packed {
        cmd_state_t state;
        logic prepared;
        logic frozen;
        logic lock_enabled;
        logic sel_master;
        logic enhanced;
        logic mismatch;
        logic [7:0] word_idx;
        logic [31:0] lba;
        logic [7:0] error_flags;
        logic [7:0] status;
        logic [IRQ_WIDTH-1:0] irq_status;
        logic [IRQ_WIDTH-1:0] irq_mask;
        logic [31:0] native_max;
        logic [15:0] erase_time;
        logic [15:0] enh_erase_time;
        logic [PW_WORDS*16-1:0] user_pw;
        logic [PW_WORDS*16-1:0] master_pw;
        logic [3:0] pw_wr_idx;
        logic [31:0] rdata;
        logic media_wr;
    } core_state_t;
endpackage

// *** src/sec_erase_ctrl.sv ***
// command interpreter for the lock erase, erase prepare and freeze commands
//
// Overview of operation
// RL1: opcode F4h written to the command register starts the secure erase.
// RL2: erase runs from block zero up to the native maximum block.
// RL3: after the erase opcode, exactly one data sector is taken from the host.
// RL4: a password mismatch aborts the erase with an aborted-command error.
// RL5: control word bit 0 selects user (0) or master (1) password.
// RL6: control word bit 1 selects enhanced (1) or normal (0) erase.
// RL7: erase writes zeros only, with no read-back check.
// RL8: defect list and reassignment records are never touched.
// RL9: erase not directly preceded by the prepare command is aborted.
// RL10: erase completion disables lock but keeps the master password.
// RL11: with lock already disabled, no password compare is made.
// RL12: identify word 89 reports the normal erase duration.
// RL13: identify word 90 reports the enhanced erase duration.
// RL14: opcode F5h enters the frozen state at once.
// RL15: while frozen, lock-changing commands are rejected.
// RL16: frozen state persists until power removal; nothing clears it.
// RL17: opcode F3h transfers no data and arms the following erase.
// RL18: any rejected command sets abort and error flags, then clears busy.
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module sec_erase_ctrl (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic irq_o,
    output sec_erase_pkg::media_req_t media_o,
    output logic media_valid_o,
    input wire logic media_ready_i,
    output logic [15:0] ident_word89_o,
    output logic [15:0] ident_word90_o,
    output logic frozen_o
);
    import sec_erase_pkg::*;

    core_state_t cur;
    core_state_t next_cur;
    logic [15:0] pw_word [PW_WORDS];
    logic [15:0] sel_word [PW_WORDS];
    logic cmd_wr;
    logic data_wr;
    logic lock_cmd;

    // split the stored passwords into words for the per-word compare
    genvar g;
    generate
        for (g = 0; g < PW_WORDS; g++) begin : g_pw
            assign pw_word[g] = cur.user_pw[g*16 +: 16];
            assign sel_word[g] = cur.master_pw[g*16 +: 16];
        end
    endgenerate

    assign cmd_wr = wr_i && (addr_i == REG_COMMAND);
    assign data_wr = wr_i && (addr_i == REG_DATA);
    assign lock_cmd = (wdata_i[7:0] == OP_SET_PASSWORD) || (wdata_i[7:0] == OP_UNLOCK)
        || (wdata_i[7:0] == OP_DISABLE_PASSWORD) || (wdata_i[7:0] == OP_ERASE_UNIT);

    always_comb begin
        logic [IRQ_WIDTH-1:0] ev;
        logic [15:0] exp_word;
        logic [3:0] widx;
        ev = '0;
        exp_word = '0;
        widx = '0;
        next_cur = cur;
        next_cur.media_wr = 1'b0;
        next_cur.rdata = '0;

        // register reads, data valid one cycle after the strobe
        if (rd_i) begin
            case (addr_i)
                REG_ERROR_FLAGS: next_cur.rdata = {24'h0, cur.error_flags};
                REG_COMPLETION_STATUS: next_cur.rdata = {24'h0, cur.status};
                REG_IRQ_STATUS: next_cur.rdata = {29'h0, cur.irq_status};
                REG_IRQ_MASK: next_cur.rdata = {29'h0, cur.irq_mask};
                REG_NATIVE_MAX: next_cur.rdata = cur.native_max;
                REG_LOCK_STATE: next_cur.rdata = {29'h0, cur.frozen, cur.lock_enabled,
                    cur.prepared};
                REG_ERASE_TIME: next_cur.rdata = {16'h0, cur.erase_time};
                REG_ENH_ERASE_TIME: next_cur.rdata = {16'h0, cur.enh_erase_time};
                default: next_cur.rdata = '0;
            endcase
        end

        // configuration writes; the password ports model stored secrets
        if (wr_i) begin
            case (addr_i)
                REG_IRQ_MASK: next_cur.irq_mask = wdata_i[IRQ_WIDTH-1:0];
                REG_NATIVE_MAX: next_cur.native_max = wdata_i;
                REG_ERASE_TIME: next_cur.erase_time = wdata_i[15:0];
                REG_ENH_ERASE_TIME: next_cur.enh_erase_time = wdata_i[15:0];
                REG_USER_PW: begin
                    next_cur.user_pw[cur.pw_wr_idx*16 +: 16] = wdata_i[15:0];
                    next_cur.pw_wr_idx = cur.pw_wr_idx + 4'h1;
                    next_cur.lock_enabled = 1'b1;
                end
                REG_MASTER_PW: begin
                    next_cur.master_pw[cur.pw_wr_idx*16 +: 16] = wdata_i[15:0];
                    next_cur.pw_wr_idx = cur.pw_wr_idx + 4'h1;
                end
                default: ;
            endcase
        end

        case (cur.state)
            ST_IDLE: begin
                if (cmd_wr) begin
                    next_cur.error_flags = '0;
                    next_cur.status[ST_ERR_BIT] = 1'b0;
                    // any command other than prepare disarms the erase
                    next_cur.prepared = 1'b0; // RL9
                    if (cur.frozen && lock_cmd) begin
                        next_cur.error_flags[ERR_ABORT_BIT] = 1'b1; // RL15 RL18
                        next_cur.status[ST_ERR_BIT] = 1'b1; // RL18
                        ev[IRQ_ABORT_BIT] = 1'b1;
                    end else if (wdata_i[7:0] == OP_ERASE_UNIT) begin // RL1
                        next_cur.status[ST_BSY_BIT] = 1'b0;
                        next_cur.status[ST_DRQ_BIT] = 1'b1; // RL3
                        next_cur.word_idx = '0;
                        next_cur.mismatch = 1'b0;
                        next_cur.state = ST_RECV;
                        // remember arming across the data phase
                        next_cur.sel_master = cur.prepared; // RL9
                        ev[IRQ_DRQ_BIT] = 1'b1;
                    end else if (wdata_i[7:0] == OP_ERASE_PREPARE) begin
                        next_cur.prepared = 1'b1; // RL17
                        ev[IRQ_DONE_BIT] = 1'b1;
                    end else if (wdata_i[7:0] == OP_FREEZE) begin
                        next_cur.frozen = 1'b1; // RL14
                        ev[IRQ_DONE_BIT] = 1'b1;
                    end else begin
                        // other opcodes are not handled by this block
                        next_cur.error_flags[ERR_ABORT_BIT] = 1'b1; // RL18
                        next_cur.status[ST_ERR_BIT] = 1'b1; // RL18
                        ev[IRQ_ABORT_BIT] = 1'b1;
                    end
                end
            end
            ST_RECV: begin
                // one 256-word sector, one word per data write
                if (data_wr) begin // RL3
                    widx = 4'(cur.word_idx - PW_FIRST_WORD);
                    exp_word = cur.enhanced ? sel_word[widx] : pw_word[widx];
                    if (cur.word_idx == 8'h00) begin
                        next_cur.enhanced = wdata_i[CW_IDENT_BIT]; // RL5
                        next_cur.lba = {31'h0, wdata_i[CW_MODE_BIT]}; // RL6
                    end else if (cur.word_idx >= PW_FIRST_WORD
                        && cur.word_idx <= PW_LAST_WORD) begin
                        if (wdata_i[15:0] != exp_word) begin
                            next_cur.mismatch = 1'b1; // RL4
                        end
                    end
                    next_cur.word_idx = cur.word_idx + 8'h01;
                    if (cur.word_idx == SECTOR_LAST_WORD) begin
                        next_cur.status[ST_DRQ_BIT] = 1'b0;
                        next_cur.status[ST_BSY_BIT] = 1'b1;
                        next_cur.state = ST_CHECK;
                    end
                end
            end
            ST_CHECK: begin
                next_cur.prepared = 1'b0;
                // lba held the mode bit during the sector; move it out
                next_cur.mismatch = cur.mismatch && cur.lock_enabled; // RL11
                if (!cur.sel_master || (cur.mismatch && cur.lock_enabled)) begin // RL9 RL4
                    next_cur.error_flags[ERR_ABORT_BIT] = 1'b1; // RL18
                    next_cur.status[ST_ERR_BIT] = 1'b1; // RL18
                    next_cur.status[ST_BSY_BIT] = 1'b0; // RL18
                    next_cur.state = ST_IDLE;
                    ev[IRQ_ABORT_BIT] = 1'b1;
                end else begin
                    next_cur.enhanced = cur.lba[0];
                    next_cur.lba = '0; // RL2
                    next_cur.state = ST_ERASE;
                end
            end
            ST_ERASE: begin
                // zero write only; the defect and reassign records sit outside
                next_cur.media_wr = 1'b1; // RL7 RL8
                if (cur.media_wr && media_ready_i) begin
                    if (cur.lba == cur.native_max) begin // RL2
                        next_cur.media_wr = 1'b0;
                        next_cur.state = ST_DONE;
                    end else begin
                        next_cur.lba = cur.lba + 32'h1;
                    end
                end
            end
            ST_DONE: begin
                // master password is kept on purpose
                next_cur.lock_enabled = 1'b0; // RL10
                next_cur.status[ST_BSY_BIT] = 1'b0;
                next_cur.state = ST_IDLE;
                ev[IRQ_DONE_BIT] = 1'b1;
            end
            default: next_cur.state = ST_IDLE;
        endcase

        // frozen is never cleared by any path above
        next_cur.frozen = next_cur.frozen | cur.frozen; // RL16

        // sticky events: set wins over write-one-to-clear
        if (wr_i && addr_i == REG_IRQ_STATUS) begin
            next_cur.irq_status = cur.irq_status & ~wdata_i[IRQ_WIDTH-1:0];
        end
        next_cur.irq_status = next_cur.irq_status | ev;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cur <= '{state: ST_IDLE, status: STATUS_IDLE, native_max: NATIVE_MAX_RESET,
                erase_time: ERASE_TIME_RESET, enh_erase_time: ENH_ERASE_TIME_RESET,
                default: '0};
        end else begin
            cur <= next_cur;
        end
    end

    assign rdata_o = cur.rdata;
    assign irq_o = |(cur.irq_status & cur.irq_mask);
    assign media_o = '{lba: cur.lba, wr: cur.media_wr};
    assign media_valid_o = cur.media_wr;
    assign ident_word89_o = cur.erase_time; // RL12
    assign ident_word90_o = cur.enh_erase_time; // RL13
    assign frozen_o = cur.frozen;
endmodule

// *** verification/sec_erase_ctrl_assertions.sv ***
// concurrent checks on the erase and freeze interpreter ports
`timescale 1ns/1ps
module sec_erase_ctrl_checker
    import sec_erase_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic irq_o,
    input wire sec_erase_pkg::media_req_t media_o,
    input wire logic media_valid_o,
    input wire logic media_ready_i,
    input wire logic [15:0] ident_word89_o,
    input wire logic [15:0] ident_word90_o,
    input wire logic frozen_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_beat;
        media_valid_o && media_ready_i;
    endsequence
    sequence s_freeze_wr;
        wr_i && addr_i == REG_COMMAND && wdata_i[7:0] == OP_FREEZE;
    endsequence
    a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 32'h0)
        else $error("read data not zero outside read");
    a_media_held: assert property (media_valid_o && !media_ready_i |=>
        media_valid_o && $stable(media_o.lba)) else $error("zero write dropped");
    a_lba_steps: assert property (s_beat |=> !media_valid_o ||
        media_o.lba == $past(media_o.lba) + 32'h1) else $error("block skipped");
    a_first_lba_zero: assert property ($rose(media_valid_o) |-> media_o.lba == 32'h0)
        else $error("erase not from block zero");
    a_zero_write_only: assert property (media_valid_o |-> media_o.wr)
        else $error("erase request not a write");
    a_freeze_enters: assert property (s_freeze_wr |-> ##[1:3] frozen_o)
        else $error("freeze not entered");
    a_frozen_sticky: assert property (frozen_o |=> frozen_o)
        else $error("frozen state left");
    a_frozen_no_erase: assert property (frozen_o |-> !$rose(media_valid_o))
        else $error("erase ran while frozen");
endmodule

bind sec_erase_ctrl sec_erase_ctrl_checker u_sec_erase_ctrl_checker (.mclk_i, .rst_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o, .media_o, .media_valid_o,
    .media_ready_i, .ident_word89_o, .ident_word90_o, .frozen_o);

// *** verification/media_sink.sv ***
// media side model taking zero-write requests with a stall pattern
`timescale 1ns/1ps
module media_sink
    import sec_erase_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire sec_erase_pkg::media_req_t media_i,
    input wire logic valid_i,
    output logic ready_o,
    output logic [31:0] count_o,
    output logic [31:0] bad_o
);
    logic [31:0] expect_lba;
    logic [1:0] phase;
    // half of all cycles stall, so requests must be held
    assign ready_o = phase[1];
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            phase <= 2'h0;
            count_o <= 32'h0;
            bad_o <= 32'h0;
            expect_lba <= 32'h0;
        end else begin
            phase <= phase + 2'h1;
            if (!valid_i) begin
                expect_lba <= 32'h0;
            end else if (ready_o) begin
                if (media_i.lba !== expect_lba || media_i.wr !== 1'h1) begin
                    bad_o <= bad_o + 32'h1;
                end
                count_o <= count_o + 32'h1;
                expect_lba <= media_i.lba + 32'h1;
            end
        end
    end
endmodule

// *** verification/sec_erase_ctrl_test.sv ***
// register-level test of the erase and freeze interpreter
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end
module sec_erase_ctrl_test;
    import sec_erase_pkg::*;
    logic mclk_i = 1'h0;
    logic rst_i = 1'h1;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'h0;
    logic rd_i = 1'h0;
    logic [31:0] rdata_o;
    logic irq_o;
    media_req_t media_o;
    logic media_valid_o;
    logic media_ready_i;
    logic [15:0] w89;
    logic [15:0] w90;
    logic frozen_o;
    logic [31:0] sink_count;
    logic [31:0] sink_bad;
    logic [31:0] d;
    int err_total = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #2.5 mclk_i = ~mclk_i;
    sec_erase_ctrl u_sec_erase_ctrl (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .irq_o, .media_o, .media_valid_o, .media_ready_i,
        .ident_word89_o(w89), .ident_word90_o(w90), .frozen_o);
    media_sink u_media_sink (.mclk_i, .rst_i, .media_i(media_o), .valid_i(media_valid_o),
        .ready_o(media_ready_i), .count_o(sink_count), .bad_o(sink_bad));
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            conclude();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'h1;
        @(posedge mclk_i);
        wr_i <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'h1;
        @(posedge mclk_i);
        rd_i <= 1'h0;
        #1 v = rdata_o;
    endtask
    task automatic wait_idle();
        logic [31:0] s;
        s = 32'hFF;
        for (int i = 0; i < 2000 && (s[ST_BSY_BIT] || s[ST_DRQ_BIT]); i++)
            rd(REG_COMPLETION_STATUS, s);
        `CHK(s[ST_BSY_BIT], 1'h0)
    endtask
    task automatic cmd(input logic [7:0] op);
        wr(REG_COMMAND, {24'h0, op});
        wait_idle();
    endtask
    task automatic setpw(input logic [3:0] a, input logic [15:0] base);
        for (int i = 1; i <= 16; i++) wr(a, {16'h0, base + 16'(i)});
    endtask
    // prep: 0 none, 1 prepare, 2 prepare followed by another command
    task automatic erase(input int prep, input logic [15:0] cw, input logic [15:0] base,
        input logic abort);
        logic [31:0] n0;
        n0 = sink_count;
        if (prep != 0) cmd(OP_ERASE_PREPARE);
        if (prep == 2) cmd(8'h00);
        wr(REG_COMMAND, {24'h0, OP_ERASE_UNIT});
        for (int i = 0; i < 256; i++) wr(REG_DATA, (i == 0) ? {16'h0, cw} :
            (i <= 16) ? {16'h0, base + 16'(i)} : 32'h0);
        wait_idle();
        rd(REG_ERROR_FLAGS, d);
        `CHK(d[ERR_ABORT_BIT], abort)
        rd(REG_COMPLETION_STATUS, d);
        `CHK(d[ST_ERR_BIT], abort)
        `CHK(sink_count - n0, abort ? 32'h0 : 32'h4)
    endtask
    initial begin
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'h0;
        rd(REG_COMPLETION_STATUS, d);
        `CHK(d[7:0], STATUS_IDLE)
        rd(REG_NATIVE_MAX, d);
        `CHK(d, NATIVE_MAX_RESET)
        rd(4'hF, d);
        `CHK(d, 32'h0)
        `CHK(w89, ERASE_TIME_RESET)
        `CHK(w90, ENH_ERASE_TIME_RESET)
        wr(REG_ERASE_TIME, 32'h0000_1234);
        wr(REG_ENH_ERASE_TIME, 32'h0000_5678);
        rd(REG_ERASE_TIME, d);
        `CHK(d, 32'h0000_1234)
        `CHK(w89, 16'h1234)
        `CHK(w90, 16'h5678)
        $display("test reset values done");
        wr(REG_NATIVE_MAX, 32'h3);
        erase(0, 16'h0, 16'h1000, 1'h1);
        `CHK(irq_o, 1'h0)
        wr(REG_IRQ_MASK, 32'h3);
        wr(REG_IRQ_STATUS, 32'h7);
        setpw(REG_USER_PW, 16'h1000);
        rd(REG_LOCK_STATE, d);
        `CHK(d[1], 1'h1)
        erase(1, 16'h0, 16'h2000, 1'h1);
        erase(2, 16'h0, 16'h1000, 1'h1);
        setpw(REG_MASTER_PW, 16'h3000);
        erase(1, 16'h1, 16'h1000, 1'h1);
        erase(1, 16'h3, 16'h3000, 1'h0);
        `CHK(irq_o, 1'h1)
        rd(REG_IRQ_STATUS, d);
        `CHK(d[IRQ_WIDTH-1:0], 3'h7)
        rd(REG_LOCK_STATE, d);
        `CHK(d[1], 1'h0)
        $display("test password erase done");
        erase(1, 16'h0, 16'h5555, 1'h0);
        wr(REG_IRQ_STATUS, 32'h7);
        @(posedge mclk_i);
        #1 `CHK(irq_o, 1'h0)
        setpw(REG_USER_PW, 16'h1000);
        erase(1, 16'h1, 16'h3000, 1'h0);
        $display("test lock off and master done");
        cmd(OP_FREEZE);
        `CHK(frozen_o, 1'h1)
        erase(1, 16'h0, 16'h5555, 1'h1);
        cmd(OP_UNLOCK);
        rd(REG_ERROR_FLAGS, d);
        `CHK(d[ERR_ABORT_BIT], 1'h1)
        cmd(OP_SET_PASSWORD);
        rd(REG_ERROR_FLAGS, d);
        `CHK(d[ERR_ABORT_BIT], 1'h1)
        cmd(OP_DISABLE_PASSWORD);
        rd(REG_ERROR_FLAGS, d);
        `CHK(d[ERR_ABORT_BIT], 1'h1)
        `CHK(frozen_o, 1'h1)
        `CHK(sink_bad, 32'h0)
        $display("test freeze done");
        // reset stands in for power removal, the only way out of frozen
        rst_i <= 1'h1;
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'h0;
        rd(REG_LOCK_STATE, d);
        `CHK(d[2:0], 3'h0)
        `CHK(frozen_o, 1'h0)
        $display("test power cycle done");
        conclude();
    end
endmodule
